// ### psm_pkg.sv
// Package of constants and types shared by the power-saving mode ends
package psm_pkg;
  // Clock control register bit positions
  localparam int WAKE_BIT = 6;
  localparam int RC_WATCHDOG_ENABLE_BIT = 5;
  localparam int WDRST_BIT = 4;
  localparam logic [7:0] CLKCTL_RESET = 8'h00;
  // Stabilisation counter runs 00 to FF
  localparam logic [7:0] STAB_LAST = 8'hFF;
  // Prescaler tap used while the wake-up timer runs
  localparam int PRESCALE_DIV = 2048;
  localparam int PRESCALE_W = 11;
  // APB register offsets; the host controller decodes all but OFF_PERIOD
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CLKCTL = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  // Release source count: reset included
  localparam int NUM_SRC = 4;

  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_STOP = 5'b00010,
    ST_RCSTOP = 5'b00100,
    ST_WAKE = 5'b01000,
    ST_STAB = 5'b10000
  } psm_state_t;

  // Decode the mode selected by the clock control byte
  function automatic psm_state_t modeOf(input logic [7:0] ctl);
    if (ctl[WAKE_BIT]) begin
      return ST_WAKE;
    end else if (ctl[RC_WATCHDOG_ENABLE_BIT]) begin
      return ST_RCSTOP;
    end
    return ST_STOP;
  endfunction : modeOf
endpackage : psm_pkg

// ### psm_if.sv
// Interface joining the core-side controller and the power-saving sequencer
`timescale 1ns/1ps
interface psm_if;
  logic stopReq;
  logic [7:0] clockControl;
  logic masterIrqEnable;
  logic watchdogIrqEnable;
  logic stopped;
  logic oscRun;
  logic clkGate;
  logic wakeVector;
  logic wakeResume;
  logic wdtIrqTake;
  logic intReset;
  modport device (
    input stopReq, clockControl, masterIrqEnable, watchdogIrqEnable,
    output stopped, oscRun, clkGate, wakeVector, wakeResume, wdtIrqTake,
    intReset
  );
  modport host (
    output stopReq, clockControl, masterIrqEnable, watchdogIrqEnable,
    input stopped, oscRun, clkGate, wakeVector, wakeResume, wdtIrqTake,
    intReset
  );
endinterface : psm_if

// ### psm_sync.sv
// Two-flop synchroniser bank for asynchronous wake pins
`timescale 1ns/1ps
module psm_sync #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : psm_sync

// ### psm_device.sv
// Power-saving mode sequencer of the microcontroller
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Stop with wake bit 0 enters full stop, or watchdog stop if watchdog enable bit set
// - Stop with wake bit 1 enters wake timer
// - Full stop halts oscillator, holds all state
// - Ports keep held data and direction
// - Program counter holds next instruction address
// - Firmware writes clock control as whole bytes
// - Firmware puts two no-ops after stop
// - Full stop ends on reset or interrupt
// - Wake timer mode accepts listed release sources
// - Irq enable picks vectoring or plain resume
// - Interrupt wake counts stabiliser 00 to FF
// - Firmware sets prescaler for over 20 ms
// - Watchdog stop keeps RC oscillator running
// - Watchdog enable bit selects watchdog stop
// - Watchdog release may run watchdog service
// - Watchdog reset select raises internal reset
// - Wake mode runs prescaler 2048, timers only
// - Firmware selects 2048 clock before wake mode
// - Timer period register sets wake period
// - Wake mode release skips stabilisation
module psm_device #(
  parameter int PERIOD_W = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  psm_if.device link,
  input wire logic [3:0] extIrqPins,
  input wire logic [1:0] eventInputs,
  input wire logic spiEvent,
  input wire logic rcWatchdogTick,
  input wire logic [PERIOD_W-1:0] timerPeriod,
  input wire logic [7:0] portData,
  input wire logic [7:0] portDir,
  output logic [7:0] portOut,
  output logic [7:0] portOe,
  output logic prescaleTick,
  output logic timerOverflow,
  output logic rcOscRun,
  output logic [7:0] stabCount
);
  localparam int PRESCALE_W_L = psm_pkg::PRESCALE_W;
  psm_pkg::psm_state_t state_reg;
  logic [7:0] ctlHeld_reg;
  logic rstWake_reg;
  logic [PRESCALE_W_L-1:0] preCnt_reg;
  logic [PERIOD_W-1:0] timerCnt_reg;
  logic [6:0] pinSync;
  logic [6:0] pinPrev_reg;
  logic pinEdge;
  logic wdtEvent;

  psm_sync #(.W(7)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din({spiEvent, eventInputs, extIrqPins}),
    .dout(pinSync)
  );
  // Pin events and the RC watchdog; watchdog tick is assumed synchronous
  assign pinEdge = |(pinSync & ~pinPrev_reg);
  assign wdtEvent = rcWatchdogTick;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinPrev_reg <= '0;
    end else begin
      pinPrev_reg <= pinSync;
    end
  end

  // Mode sequencer; reset itself is the remaining release source
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= psm_pkg::ST_RUN;
      ctlHeld_reg <= psm_pkg::CLKCTL_RESET;
    end else begin
      case (state_reg)
        psm_pkg::ST_RUN: begin
          if (link.stopReq) begin
            ctlHeld_reg <= link.clockControl;
            state_reg <= psm_pkg::modeOf(link.clockControl);
          end
        end
        psm_pkg::ST_STOP: begin
          if (pinEdge) state_reg <= psm_pkg::ST_STAB;
        end
        psm_pkg::ST_RCSTOP: begin
          if (pinEdge || wdtEvent) state_reg <= psm_pkg::ST_STAB;
        end
        psm_pkg::ST_WAKE: begin
          // Oscillator never stopped, so no stabilisation wait
          if (pinEdge || wdtEvent || timerOverflow) begin
            state_reg <= psm_pkg::ST_RUN;
          end
        end
        psm_pkg::ST_STAB: begin
          if (stabCount == psm_pkg::STAB_LAST) state_reg <= psm_pkg::ST_RUN;
        end
        default: state_reg <= psm_pkg::ST_RUN;
      endcase
    end
  end

  // Stabilisation counter from 00 to FF after an interrupt wake
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stabCount <= 8'h00;
    end else if (state_reg == psm_pkg::ST_STAB) begin
      stabCount <= stabCount + 8'h01;
    end else begin
      stabCount <= 8'h00;
    end
  end

  // Marks a watchdog reset: the core restarts, so no wake is reported
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstWake_reg <= 1'b0;
    end else if (state_reg == psm_pkg::ST_RCSTOP && wdtEvent &&
                 ctlHeld_reg[psm_pkg::WDRST_BIT]) begin
      rstWake_reg <= 1'b1;
    end else if (state_reg == psm_pkg::ST_RUN) begin
      rstWake_reg <= 1'b0;
    end
  end

  // Prescaler runs in normal mode and, at its 2048 tap, in wake mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_reg <= '0;
      prescaleTick <= 1'b0;
    end else if (state_reg == psm_pkg::ST_RUN ||
                 state_reg == psm_pkg::ST_WAKE) begin
      preCnt_reg <= preCnt_reg + 1'b1;
      prescaleTick <= &preCnt_reg;
    end else begin
      prescaleTick <= 1'b0;
    end
  end

  // Wake timer counts prescaler ticks up to the period register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timerCnt_reg <= '0;
      timerOverflow <= 1'b0;
    end else if (state_reg == psm_pkg::ST_WAKE && prescaleTick) begin
      if (timerCnt_reg >= timerPeriod) begin
        timerCnt_reg <= '0;
        timerOverflow <= 1'b1;
      end else begin
        timerCnt_reg <= timerCnt_reg + 1'b1;
        timerOverflow <= 1'b0;
      end
    end else begin
      if (state_reg != psm_pkg::ST_WAKE) timerCnt_reg <= '0;
      timerOverflow <= 1'b0;
    end
  end

  // Port pins frozen at the held values while not running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      portOut <= 8'h00;
      portOe <= 8'h00;
    end else if (state_reg == psm_pkg::ST_RUN) begin
      portOut <= portData;
      portOe <= portDir;
    end else begin
      portOut <= portOut;
      portOe <= portOe;
    end
  end

  // Status and clock gating outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link.stopped <= 1'b0;
      link.oscRun <= 1'b1;
      link.clkGate <= 1'b0;
      rcOscRun <= 1'b0;
    end else begin
      link.stopped <= (state_reg != psm_pkg::ST_RUN);
      link.oscRun <= !(state_reg == psm_pkg::ST_STOP ||
                       state_reg == psm_pkg::ST_RCSTOP);
      link.clkGate <= (state_reg != psm_pkg::ST_RUN);
      rcOscRun <= (state_reg == psm_pkg::ST_RCSTOP);
    end
  end

  // Release outcome, one-cycle pulses: internal reset on leaving watchdog stop, the others on return to run
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link.wakeVector <= 1'b0;
      link.wakeResume <= 1'b0;
      link.wdtIrqTake <= 1'b0;
      link.intReset <= 1'b0;
    end else begin
      link.wakeVector <= 1'b0;
      link.wakeResume <= 1'b0;
      link.wdtIrqTake <= 1'b0;
      link.intReset <= 1'b0;
      if (state_reg == psm_pkg::ST_RCSTOP && wdtEvent &&
          ctlHeld_reg[psm_pkg::WDRST_BIT]) begin
        link.intReset <= 1'b1;
      end else if ((state_reg == psm_pkg::ST_STAB && !rstWake_reg &&
                    stabCount == psm_pkg::STAB_LAST) ||
                   (state_reg == psm_pkg::ST_WAKE &&
                    (pinEdge || wdtEvent || timerOverflow))) begin
        if (link.masterIrqEnable) begin
          link.wakeVector <= 1'b1;
          link.wdtIrqTake <= link.watchdogIrqEnable &&
                             !ctlHeld_reg[psm_pkg::WDRST_BIT] &&
                             ctlHeld_reg[psm_pkg::RC_WATCHDOG_ENABLE_BIT];
        end else begin
          link.wakeResume <= 1'b1;
        end
      end
    end
  end
endmodule : psm_device

// ### psm_host.sv
// Core-side controller: APB registers issue stop and watch release
`timescale 1ns/1ps
module psm_host (
  input wire logic mclk,
  input wire logic reset_n,
  psm_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic access;
  logic [3:0] flags_reg;
  assign access = psel && penable;

  // Control: bit0 stop pulse, bit1 irq enable, bit2 watchdog irq enable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link.stopReq <= 1'b0;
      link.masterIrqEnable <= 1'b0;
      link.watchdogIrqEnable <= 1'b0;
      link.clockControl <= psm_pkg::CLKCTL_RESET;
    end else begin
      link.stopReq <= 1'b0;
      if (access && pwrite && paddr == psm_pkg::OFF_CTRL) begin
        link.stopReq <= pwdata[0] && !link.stopped;
        link.masterIrqEnable <= pwdata[1];
        link.watchdogIrqEnable <= pwdata[2];
      end
      if (access && pwrite && paddr == psm_pkg::OFF_CLKCTL) begin
        link.clockControl <= pwdata[7:0];
      end
    end
  end

  // Sticky release flags, set beats clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= 4'h0;
    end else begin
      flags_reg <= ((access && pwrite && paddr == psm_pkg::OFF_STATUS) ?
                    flags_reg & ~pwdata[3:0] : flags_reg) |
                   {link.intReset, link.wdtIrqTake, link.wakeResume,
                    link.wakeVector};
    end
  end

  // APB answer, zero wait states
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != psm_pkg::OFF_CTRL &&
                 paddr != psm_pkg::OFF_STATUS && paddr != psm_pkg::OFF_CLKCTL;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          psm_pkg::OFF_CTRL: prdata <= {29'h0, link.watchdogIrqEnable,
                                        link.masterIrqEnable, 1'b0};
          psm_pkg::OFF_STATUS: prdata <= {26'h0, link.oscRun, link.stopped,
                                          flags_reg};
          psm_pkg::OFF_CLKCTL: prdata <= {24'h0, link.clockControl};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : psm_host

// ### psm_props.sv
// Checker for the link between core controller and sequencer
`timescale 1ns/1ps
module psm_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic stopReq,
  input wire logic [7:0] clockControl,
  input wire logic masterIrqEnable,
  input wire logic watchdogIrqEnable,
  input wire logic stopped,
  input wire logic oscRun,
  input wire logic wakeVector,
  input wire logic wakeResume,
  input wire logic wdtIrqTake,
  input wire logic intReset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // Halt reached within two edges, oscillator as the mode wants
  sequence s_parked(bit run);
    ##[1:2] (stopped && oscRun == run);
  endsequence
  sequence s_stopFull;
    stopReq && !clockControl[psm_pkg::WAKE_BIT] &&
      !clockControl[psm_pkg::RC_WATCHDOG_ENABLE_BIT];
  endsequence
  sequence s_stopRc;
    stopReq && !clockControl[psm_pkg::WAKE_BIT] &&
      clockControl[psm_pkg::RC_WATCHDOG_ENABLE_BIT];
  endsequence
  property p_fullStop;
    s_stopFull |-> s_parked(1'b0);
  endproperty
  a_fullStop: assert property (p_fullStop)
    else $error("full stop not entered");
  property p_wakeStop;
    stopReq && clockControl[psm_pkg::WAKE_BIT] |-> s_parked(1'b1);
  endproperty
  a_wakeStop: assert property (p_wakeStop)
    else $error("wake timer mode not entered");
  property p_rcStop;
    s_stopRc |-> s_parked(1'b0);
  endproperty
  a_rcStop: assert property (p_rcStop)
    else $error("watchdog stop not entered");
  // Internal reset may reload the byte, so skip just after it
  property p_hold;
    stopped && $past(stopped) && !$past(intReset) && !$past(intReset, 2)
      |-> $stable(clockControl);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control byte changed while halted");
  property p_noRestop;
    stopped |-> !stopReq;
  endproperty
  a_noRestop: assert property (p_noRestop)
    else $error("second stop issued while halted");
  property p_vecSel;
    wakeVector |-> masterIrqEnable && !wakeResume;
  endproperty
  a_vecSel: assert property (p_vecSel)
    else $error("vector taken with irq disabled");
  property p_resSel;
    wakeResume |-> !masterIrqEnable;
  endproperty
  a_resSel: assert property (p_resSel)
    else $error("plain resume with irq enabled");
  property p_wdtIsr;
    wdtIrqTake |-> masterIrqEnable && watchdogIrqEnable &&
      !clockControl[psm_pkg::WDRST_BIT];
  endproperty
  a_wdtIsr: assert property (p_wdtIsr)
    else $error("watchdog service without its enables");
  property p_intRst;
    intReset |-> clockControl[psm_pkg::WDRST_BIT] &&
      clockControl[psm_pkg::RC_WATCHDOG_ENABLE_BIT];
  endproperty
  a_intRst: assert property (p_intRst)
    else $error("internal reset without reset select");
  property p_runAfter;
    wakeVector || wakeResume |-> ##[0:1] (!stopped && oscRun);
  endproperty
  a_runAfter: assert property (p_runAfter)
    else $error("release pulse while still halted");
endmodule : psm_props

// ### tb_top.sv
// Testbench joining both ends, driven over APB
`timescale 1ns/1ps
module tb_top;
  // Mode bytes and release sources: 0 pin,1 event,2 spi,3 timer,4 tick
  localparam logic [7:0] CTL_TAB [8] = '{8'h0E, 8'h2E, 8'h4E, 8'h4E,
    8'h4E, 8'h4E, 8'h3E, 8'h2E};
  localparam int SRC_TAB [8] = '{0, 0, 0, 1, 2, 3, 4, 4};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, prescaleTick, timerOverflow, rcOscRun;
  logic [3:0] extIrqPins = 4'h0;
  logic [1:0] eventInputs = 2'h0;
  logic spiEvent = 1'b0, rcWatchdogTick = 1'b0;
  // Short wake period keeps the timer case brief
  logic [15:0] timerPeriod = 16'h0002;
  logic [7:0] portData = 8'h00, portDir = 8'h00, portOut, portOe, stabCount;
  int err_total = 0, num_checks = 0, seed = 12;
  psm_if link();
  always #12.5 mclk = ~mclk;
  psm_device psm_device_i (.mclk(mclk), .reset_n(reset_n), .link(link),
    .extIrqPins(extIrqPins), .eventInputs(eventInputs),
    .spiEvent(spiEvent), .rcWatchdogTick(rcWatchdogTick),
    .timerPeriod(timerPeriod), .portData(portData), .portDir(portDir),
    .portOut(portOut), .portOe(portOe), .prescaleTick(prescaleTick),
    .timerOverflow(timerOverflow), .rcOscRun(rcOscRun),
    .stabCount(stabCount));
  psm_host psm_host_i (.mclk(mclk), .reset_n(reset_n), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  psm_props psm_props_i (.mclk(mclk), .reset_n(reset_n),
    .stopReq(link.stopReq), .clockControl(link.clockControl),
    .masterIrqEnable(link.masterIrqEnable),
    .watchdogIrqEnable(link.watchdogIrqEnable), .stopped(link.stopped),
    .oscRun(link.oscRun), .wakeVector(link.wakeVector),
    .wakeResume(link.wakeResume), .wdtIrqTake(link.wdtIrqTake),
    .intReset(link.intReset));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait for the slave
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // Watchdog sized well above the timer wake case
  initial begin
    #(25 * 80000);
    err_total++;
    close_out();
  end
  initial begin
    logic [31:0] q;
    logic e, ifl, wen, hiSeen, tov, ptk;
    logic [7:0] ctl, hd, hr;
    logic [3:0] vecs, ev;
    logic [2:0] want;
    int src, n;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b0, psm_pkg::OFF_STATUS, 32'h0000_0000, q, e);
    chk(q, 32'h0000_0020);
    apb(1'b0, psm_pkg::OFF_CLKCTL, 32'h0000_0000, q, e);
    chk(q, {24'h00_0000, psm_pkg::CLKCTL_RESET});
    apb(1'b0, 8'h10, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      ctl = CTL_TAB[k];
      src = SRC_TAB[k];
      ifl = (k == 7) ? 1'b1 : 1'($random(seed));
      wen = (k == 7);
      hd = 8'($random(seed));
      hr = 8'($random(seed));
      portData <= hd;
      portDir <= hr;
      apb(1'b1, psm_pkg::OFF_CLKCTL, {24'h0, ctl}, q, e);
      apb(1'b1, psm_pkg::OFF_CTRL, {29'h0, wen, ifl, 1'b1}, q, e);
      repeat (4) @(posedge mclk);
      portData <= 8'($random(seed));
      portDir <= 8'($random(seed));
      // Second stop while halted must be ignored
      apb(1'b1, psm_pkg::OFF_CTRL, {29'h0, wen, ifl, 1'b1}, q, e);
      chk({16'h0, portOe, portOut}, {16'h0, hr, hd});
      chk({28'h0, link.clkGate, link.stopped, link.oscRun, rcOscRun},
        {28'h0, 2'b11, ctl[6], ctl[5] & ~ctl[6]});
      @(posedge mclk);
      case (src)
        0: extIrqPins <= 4'h1 << k[1:0];
        1: eventInputs <= 2'h1 << k[0];
        2: spiEvent <= 1'b1;
        4: rcWatchdogTick <= 1'b1;
        default: ;
      endcase
      n = 0;
      vecs = 4'h0;
      hiSeen = 1'b0;
      tov = 1'b0;
      ptk = 1'b0;
      // Values read at an edge are those that stood in the cycle before
      while (vecs === 4'h0 && n < 9000) begin
        @(posedge mclk);
        rcWatchdogTick <= 1'b0;
        n++;
        vecs = {link.intReset, link.wdtIrqTake, link.wakeResume,
          link.wakeVector};
        hiSeen |= (stabCount == psm_pkg::STAB_LAST);
        tov |= timerOverflow;
        ptk |= prescaleTick;
      end
      // Watchdog service rides on a vectored wake; reset stands alone
      ev = (src == 4) ? (ctl[4] ? 4'h8 : 4'h5) : (ifl ? 4'h1 : 4'h2);
      want = {!ctl[6] && !(src == 4 && ctl[4]), src == 3, src == 3};
      // A short pin wake may legally see one prescaler tick
      ptk &= (src == 3 || !ctl[6]);
      chk({29'h0, hiSeen, tov, ptk}, {29'h0, want});
      chk({28'h0, vecs}, {28'h0, ev});
      if (src < 3) begin
        chk({31'h0, ctl[6] ? n <= 8 : n >= 256}, 32'h1);
      end
      @(posedge mclk);
      extIrqPins <= 4'h0;
      eventInputs <= 2'h0;
      spiEvent <= 1'b0;
      n = 0;
      while (link.stopped !== 1'b0 && n < 600) begin
        @(posedge mclk);
        n++;
      end
      apb(1'b0, psm_pkg::OFF_STATUS, 32'h0000_0000, q, e);
      chk(q, {26'h0, 2'b10, ev});
      apb(1'b1, psm_pkg::OFF_STATUS, 32'h0000_000F, q, e);
      apb(1'b0, psm_pkg::OFF_STATUS, 32'h0000_0000, q, e);
      chk(q, 32'h0000_0020);
      $display("test %0d done", k);
    end
    close_out();
  end
endmodule : tb_top
